// ### pkg/tps_consts.svh
// timing and register map constants of the thermal protection supervisor
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

`define TPS_CLK_HZ 50000000
// hold time after core thermal shutdown, in ms (nominal 1 s, 0.8..1.2 s)
`define TPS_HOLD_MS 1000
// minimum fail-safe wait for other causes, in ms (nominal 100, 80..120)
`define TPS_MINWAIT_MS 100
`define TPS_HOLD_CYC ((`TPS_CLK_HZ / 1000) * `TPS_HOLD_MS)
`define TPS_MINWAIT_CYC ((`TPS_CLK_HZ / 1000) * `TPS_MINWAIT_MS)

// register offsets, as wide as the index field of the command address
`define TPS_A_STAT 7'h00
`define TPS_A_BUS 7'h01
`define TPS_A_CTRL 7'h02
`define TPS_A_MASK 7'h03
`define TPS_A_LIVE 7'h04
// write-and-clear access bit of the command address; reads ignore it
`define TPS_RC_BIT 7

// status bit positions
`define TPS_S_PERIPH 0
`define TPS_S_CORE 1
`define TPS_S_AUX 2
`define TPS_S_MAIN 3
`define TPS_S_BOOST 4
`define TPS_S_PREWARN 5
// control bit positions
`define TPS_C_AUX_ON 0
`define TPS_C_BOOST_EN 1

`endif

// ### pkg/tps_pkg.sv
// types of the thermal protection supervisor
`default_nettype none
package tps_pkg;
    typedef enum logic [1:0] {
        TPS_RUN = 2'b00,
        TPS_FS_HOT = 2'b01,
        TPS_FS_HOLD = 2'b11,
        TPS_FS_WAIT = 2'b10
    } tps_fs_e;

    // synchronised comparator bundle
    typedef struct packed {
        logic [3:0] xcvr_ot;
        logic boost_overtemp_flag;
        logic aux_ot;
        logic main_ot;
        logic main_pw;
    } tps_temp_s;
endpackage : tps_pkg
`default_nettype wire

// ### verilog/tps_supervisor.sv
// thermal protection supervisor: shutdown, flags, fail-safe hold, registers
//
// Contract
// - peripheral shutdown flag is OR of transceiver, boost and aux supply events.
// - core thermal flag set only by main regulator second-level detection.
// - aux supply overtemp turns output off, clears on bit, sets two flags.
// - one stage shutting down leaves other stages running.
// - transceiver overtemp disables that transmitter only, sets periph and channel fail.
// - transceiver driver re-enabled automatically once overtemp goes away.
// - main regulator overtemp enters fail-safe and sets main overtemp flag.
// - fail-safe held for about one second after main overtemp is gone.
// - thermal fail-safe enables bus and wake input wake sources, fail output.
// - boost overtemp turns boost off until software sets boost enable again.
// - thermal shutdown flags stay set; clear only works once condition is gone.
// - prewarning flag set when main regulator reaches prewarn threshold.
// - prewarning clear succeeds only after the condition has gone.
// - prewarning evaluated only in pulse-width-modulated regulator mode.
// - other fail-safe causes hold fail-safe at least about 100 ms.
`default_nettype none
`include "tps_consts.svh"

module tps_supervisor
    import tps_pkg::*;
#(
    parameter int NXCVR = 4,
    parameter int HOLD_CYC = `TPS_HOLD_CYC,
    parameter int MINWAIT_CYC = `TPS_MINWAIT_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NXCVR-1:0] xcvr_ot_in,
    input wire logic boost_overtemp_flag_in,
    input wire logic aux_ot_in,
    input wire logic main_ot_in,
    input wire logic main_pw_in,
    input wire logic main_pwm_mode,
    input wire logic other_fs_req,
    output logic [NXCVR-1:0] xcvr_tx_en,
    output logic aux_supply_output,
    output logic boost_on,
    output logic failsafe,
    output logic fail_output,
    output logic [NXCVR-1:0] xcvr_wake_en,
    output logic wake_input_en,
    output logic irq
);
    localparam int NT = NXCVR + 4;

    // ***************************************************************
    // input synchronisers
    // ***************************************************************
    // three stages; a change counts once stage two and three agree
    logic [NT-1:0] raw;
    logic [NT-1:0] s1_r;
    logic [NT-1:0] s2_r;
    logic [NT-1:0] s3_r;
    logic [NT-1:0] clean_r;
    assign raw = {xcvr_ot_in, boost_overtemp_flag_in, aux_ot_in, main_ot_in, main_pw_in};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // per-bit agreement filter, repeated for every comparator
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_flt
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    clean_r[gi] <= 1'b0;
                end else if (s2_r[gi] == s3_r[gi]) begin
                    clean_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate

    tps_temp_s t;
    assign t = clean_r;

    // ***************************************************************
    // register decode
    // ***************************************************************
    logic [6:0] addr_idx;
    logic rc_cmd;
    logic wr_stat;
    logic wr_bus;
    logic wr_ctrl;
    logic wr_mask;
    assign addr_idx = reg_addr[6:0];
    assign rc_cmd = reg_addr[`TPS_RC_BIT];
    assign wr_stat = reg_wr && rc_cmd && addr_idx == `TPS_A_STAT;
    assign wr_bus = reg_wr && rc_cmd && addr_idx == `TPS_A_BUS;
    assign wr_ctrl = reg_wr && rc_cmd && addr_idx == `TPS_A_CTRL;
    assign wr_mask = reg_wr && rc_cmd && addr_idx == `TPS_A_MASK;

    // ***************************************************************
    // control register and shutdown paths
    // ***************************************************************
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic aux_on_ctrl;
    logic boost_en_ctrl;
    assign aux_on_ctrl = ctrl_r[`TPS_C_AUX_ON];
    assign boost_en_ctrl = ctrl_r[`TPS_C_BOOST_EN];

    // hardware clear of the on bits beats a software write in the same cycle
    always_comb begin
        ctrl_nxt = wr_ctrl ? reg_wdata : ctrl_r;
        if (t.aux_ot) begin
            ctrl_nxt[`TPS_C_AUX_ON] = 1'b0;
        end
        if (t.boost_overtemp_flag) begin
            ctrl_nxt[`TPS_C_BOOST_EN] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // each stage judged only by its own comparator
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aux_supply_output <= 1'b0;
            boost_on <= 1'b0;
            xcvr_tx_en <= '0;
        end else begin
            aux_supply_output <= ctrl_nxt[`TPS_C_AUX_ON];
            boost_on <= ctrl_nxt[`TPS_C_BOOST_EN];
            xcvr_tx_en <= ~t.xcvr_ot;
        end
    end

    // ***************************************************************
    // sticky status flags
    // ***************************************************************
    logic [7:0] stat_r;
    logic [7:0] stat_set;
    logic [7:0] stat_hold;
    logic [7:0] stat_clr;
    logic [7:0] bus_r;
    logic [7:0] mask_r;
    logic periph_hot;
    assign periph_hot = |t.xcvr_ot | t.boost_overtemp_flag | t.aux_ot;

    always_comb begin
        stat_set = 8'h00;
        stat_set[`TPS_S_PERIPH] = periph_hot;
        stat_set[`TPS_S_CORE] = t.main_ot;
        stat_set[`TPS_S_AUX] = t.aux_ot;
        stat_set[`TPS_S_MAIN] = t.main_ot;
        stat_set[`TPS_S_BOOST] = t.boost_overtemp_flag;
        stat_set[`TPS_S_PREWARN] = t.main_pw && main_pwm_mode;
        // conditions still present block a clear
        stat_hold = 8'h00;
        stat_hold[`TPS_S_PERIPH] = periph_hot;
        stat_hold[`TPS_S_CORE] = t.main_ot;
        stat_hold[`TPS_S_PREWARN] = t.main_pw;
    end
    assign stat_clr = wr_stat ? (reg_wdata & ~stat_hold) : 8'h00;

    // set wins over clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stat_r <= 8'h00;
            bus_r <= 8'h00;
            mask_r <= 8'h00;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | stat_set;
            bus_r <= (bus_r & ~(wr_bus ? reg_wdata : 8'h00))
                | {{(8-NXCVR){1'b0}}, t.xcvr_ot};
            if (wr_mask) begin
                mask_r <= reg_wdata;
            end
        end
    end

    // ***************************************************************
    // fail-safe sequencer
    // ***************************************************************
    tps_fs_e fs_r;
    tps_fs_e fs_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    always_comb begin
        fs_nxt = fs_r;
        cnt_nxt = cnt_r;
        case (fs_r)
            TPS_RUN: begin
                if (t.main_ot) begin
                    fs_nxt = TPS_FS_HOT;
                end else if (other_fs_req) begin
                    fs_nxt = TPS_FS_WAIT;
                    cnt_nxt = 32'(MINWAIT_CYC - 1);
                end
            end
            TPS_FS_HOT: begin
                if (!t.main_ot) begin
                    fs_nxt = TPS_FS_HOLD;
                    cnt_nxt = 32'(HOLD_CYC - 1);
                end
            end
            TPS_FS_HOLD: begin
                if (t.main_ot) begin
                    fs_nxt = TPS_FS_HOT;
                end else if (cnt_r == 32'h0) begin
                    fs_nxt = TPS_RUN;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            TPS_FS_WAIT: begin
                // a thermal event upgrades the wait to the long hold
                if (t.main_ot) begin
                    fs_nxt = TPS_FS_HOT;
                end else if (cnt_r == 32'h0) begin
                    fs_nxt = other_fs_req ? TPS_FS_WAIT : TPS_RUN;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            default: begin
                fs_nxt = TPS_RUN;
            end
        endcase
    end

    logic fs_any;
    assign fs_any = fs_nxt != TPS_RUN;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fs_r <= TPS_RUN;
            cnt_r <= 32'h0;
            failsafe <= 1'b0;
            fail_output <= 1'b0;
            xcvr_wake_en <= '0;
            wake_input_en <= 1'b0;
        end else begin
            fs_r <= fs_nxt;
            cnt_r <= cnt_nxt;
            failsafe <= fs_any;
            fail_output <= fs_any;
            xcvr_wake_en <= {NXCVR{fs_any}};
            wake_input_en <= fs_any;
        end
    end

    // ***************************************************************
    // read port and interrupt
    // ***************************************************************
    logic [7:0] rd_mux;
    assign rd_mux = (addr_idx == `TPS_A_STAT) ? stat_r :
                    (addr_idx == `TPS_A_BUS) ? bus_r :
                    (addr_idx == `TPS_A_CTRL) ? ctrl_r :
                    (addr_idx == `TPS_A_MASK) ? mask_r :
                    (addr_idx == `TPS_A_LIVE) ? 8'(clean_r) : 8'h00;

    // read data only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq <= |(((stat_r & ~stat_clr) | stat_set) & mask_r);
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    a_aux_off: assert property (@(posedge core_clk) disable iff (rst)
        t.aux_ot |=> !aux_supply_output && stat_r[`TPS_S_AUX])
        else $error("aux output not off on overtemp");
    a_periph_or: assert property (@(posedge core_clk) disable iff (rst)
        periph_hot |=> stat_r[`TPS_S_PERIPH])
        else $error("periph flag not set");
    a_core_src: assert property (@(posedge core_clk) disable iff (rst)
        $rose(stat_r[`TPS_S_CORE]) |-> $past(t.main_ot))
        else $error("core flag set without main overtemp");
    a_tx_auto: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) |-> xcvr_tx_en == ~$past(t.xcvr_ot))
        else $error("transmitter enable wrong");
    a_boost_stay: assert property (@(posedge core_clk) disable iff (rst)
        !boost_en_ctrl && !wr_ctrl |=> !boost_on)
        else $error("boost came back without enable");
    a_flag_hold: assert property (@(posedge core_clk) disable iff (rst)
        t.main_ot && stat_r[`TPS_S_CORE] |=> stat_r[`TPS_S_CORE])
        else $error("core flag cleared while hot");
    a_pw_mode: assert property (@(posedge core_clk) disable iff (rst)
        $rose(stat_r[`TPS_S_PREWARN]) |-> $past(main_pwm_mode))
        else $error("prewarn set outside pwm mode");
    a_fs_entry: assert property (@(posedge core_clk) disable iff (rst)
        t.main_ot |=> failsafe && fail_output && wake_input_en)
        else $error("fail-safe not entered");

    // some of these hold by construction today; they guard later edits of the logic
    a_bus_fail: assert property (@(posedge core_clk) disable iff (rst)
        (t.xcvr_ot != '0) |=> ($past(t.xcvr_ot) & ~bus_r[NXCVR-1:0]) == '0)
        else $error("channel fail flag not set");
    a_ctrl_kept: assert property (@(posedge core_clk) disable iff (rst)
        !wr_ctrl && !t.aux_ot && !t.boost_overtemp_flag |=> $stable(ctrl_r))
        else $error("control bits changed without cause");
    a_aux_kept: assert property (@(posedge core_clk) disable iff (rst)
        aux_on_ctrl && !t.aux_ot && !wr_ctrl |=> aux_supply_output)
        else $error("aux output dropped by another stage");
    a_boost_off: assert property (@(posedge core_clk) disable iff (rst)
        t.boost_overtemp_flag |=> !boost_on && stat_r[`TPS_S_BOOST])
        else $error("boost not off on overtemp");
    a_pw_set: assert property (@(posedge core_clk) disable iff (rst)
        t.main_pw && main_pwm_mode |=> stat_r[`TPS_S_PREWARN])
        else $error("prewarn flag not set");
    a_pw_hold: assert property (@(posedge core_clk) disable iff (rst)
        t.main_pw && stat_r[`TPS_S_PREWARN] |=> stat_r[`TPS_S_PREWARN])
        else $error("prewarn flag cleared while hot");
    a_hold_time: assert property (@(posedge core_clk) disable iff (rst)
        fs_r == TPS_FS_HOLD && cnt_r != 32'h0 |=> failsafe)
        else $error("thermal hold ended early");
    a_min_wait: assert property (@(posedge core_clk) disable iff (rst)
        fs_r == TPS_FS_WAIT && cnt_r != 32'h0 |=> failsafe)
        else $error("minimum wait ended early");
    a_wake_src: assert property (@(posedge core_clk) disable iff (rst)
        failsafe |-> fail_output && wake_input_en && (&xcvr_wake_en))
        else $error("wake sources not enabled in fail-safe");
endmodule : tps_supervisor
`default_nettype wire

// ### tb/test_thermal_protection_supervisor.sv
// self-checking bench of the thermal protection supervisor
`default_nettype none

module test_thermal_protection_supervisor;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals and design instance
    // ****************************************
    logic core_clk, rst, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] xcvr_ot_in, xcvr_tx_en, xcvr_wake_en;
    logic boost_overtemp_flag_in, aux_ot_in, main_ot_in, main_pw_in, main_pwm_mode, other_fs_req;
    logic aux_supply_output, boost_on, failsafe, fail_output, wake_input_en, irq;
    int mismatches, checks_done;

    // short hold counts keep the fail-safe scenarios quick
    tps_supervisor #(.NXCVR(4), .HOLD_CYC(20), .MINWAIT_CYC(10)) tps_supervisor_i (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xcvr_ot_in(xcvr_ot_in), .boost_overtemp_flag_in(boost_overtemp_flag_in), .aux_ot_in(aux_ot_in),
        .main_ot_in(main_ot_in), .main_pw_in(main_pw_in), .main_pwm_mode(main_pwm_mode),
        .other_fs_req(other_fs_req), .xcvr_tx_en(xcvr_tx_en),
        .aux_supply_output(aux_supply_output), .boost_on(boost_on), .failsafe(failsafe),
        .fail_output(fail_output), .xcvr_wake_en(xcvr_wake_en),
        .wake_input_en(wake_input_en), .irq(irq));

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // ****************************************
    // bus cycles and comparison helpers
    // ****************************************
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // wait n edges, then step past the edge so outputs are settled
    task wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wt

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask : rdchk

    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // ****************************************
    // scenarios
    // ****************************************
    task t_aux;
        rdchk("unmapped", 8'h10, 8'h00);
        wr(8'h82, 8'h03);
        wr(8'h02, 8'h00); // plain access must not write
        rdchk("ctrl", 8'h02, 8'h03);
        @(posedge core_clk);
        aux_ot_in <= 1'b1;
        wt(10);
        chk("aux off", {7'h0, aux_supply_output}, 8'h00);
        chk("boost kept", {7'h0, boost_on}, 8'h01);
        rdchk("stat aux", 8'h00, 8'h05);
        rdchk("ctrl aux", 8'h02, 8'h02);
        @(posedge core_clk);
        aux_ot_in <= 1'b0;
        wt(10);
        chk("aux stays off", {7'h0, aux_supply_output}, 8'h00);
        wr(8'h82, 8'h03);
        wt(3);
        chk("aux back", {7'h0, aux_supply_output}, 8'h01);
        wr(8'h80, 8'hff);
        rdchk("stat clr", 8'h00, 8'h00);
    endtask : t_aux

    task t_boost;
        @(posedge core_clk);
        boost_overtemp_flag_in <= 1'b1;
        wt(10);
        chk("boost off", {7'h0, boost_on}, 8'h00);
        chk("aux kept", {7'h0, aux_supply_output}, 8'h01);
        rdchk("stat boost", 8'h00, 8'h11);
        @(posedge core_clk);
        boost_overtemp_flag_in <= 1'b0;
        wt(10);
        chk("boost stays off", {7'h0, boost_on}, 8'h00);
        wr(8'h82, 8'h03);
        wt(3);
        chk("boost back", {7'h0, boost_on}, 8'h01);
        wr(8'h80, 8'hff);
    endtask : t_boost

    task t_xcvr;
        @(posedge core_clk);
        xcvr_ot_in <= 4'b0100;
        wt(10);
        chk("tx en hot", {4'h0, xcvr_tx_en}, 8'h0b);
        rdchk("ctrl kept", 8'h02, 8'h03);
        rdchk("bus fail", 8'h01, 8'h04);
        rdchk("live", 8'h04, 8'h40);
        wr(8'h80, 8'hff); // clear while still hot
        rdchk("stat held", 8'h00, 8'h01);
        @(posedge core_clk);
        xcvr_ot_in <= 4'b0000;
        wt(10);
        chk("tx en back", {4'h0, xcvr_tx_en}, 8'h0f);
        rdchk("bus kept", 8'h01, 8'h04);
        wr(8'h81, 8'hff);
        rdchk("bus clr", 8'h01, 8'h00);
        wr(8'h80, 8'hff);
        rdchk("stat clr", 8'h00, 8'h00);
    endtask : t_xcvr

    task t_main;
        @(posedge core_clk);
        main_ot_in <= 1'b1;
        wt(10);
        chk("fs hot", {5'h0, failsafe, fail_output, wake_input_en}, 8'h07);
        chk("wake bus", {4'h0, xcvr_wake_en}, 8'h0f);
        rdchk("stat core", 8'h00, 8'h0a);
        wr(8'h80, 8'hff);
        rdchk("core held", 8'h00, 8'h0a);
        @(posedge core_clk);
        main_ot_in <= 1'b0;
        wt(10);
        chk("fs hold", {7'h0, failsafe}, 8'h01);
        wt(14);
        chk("fs hold last", {7'h0, failsafe}, 8'h01);
        wt(1);
        chk("fs end", {5'h0, failsafe, fail_output, wake_input_en}, 8'h00);
        wr(8'h80, 8'hff);
        rdchk("core clr", 8'h00, 8'h00);
    endtask : t_main

    task t_prewarn;
        @(posedge core_clk);
        main_pw_in <= 1'b1;
        wt(10);
        rdchk("pw ignored", 8'h00, 8'h00);
        @(posedge core_clk);
        main_pwm_mode <= 1'b1;
        wt(10);
        rdchk("pw set", 8'h00, 8'h20);
        wr(8'h80, 8'hff);
        rdchk("pw held", 8'h00, 8'h20);
        @(posedge core_clk);
        main_pw_in <= 1'b0;
        wt(10);
        wr(8'h80, 8'hff);
        rdchk("pw clr", 8'h00, 8'h00);
    endtask : t_prewarn

    task t_other;
        @(posedge core_clk);
        other_fs_req <= 1'b1;
        @(posedge core_clk);
        other_fs_req <= 1'b0;
        wt(9);
        chk("min wait", {7'h0, failsafe}, 8'h01);
        wt(1);
        chk("min wait end", {7'h0, failsafe}, 8'h00);
    endtask : t_other

    // interrupt raised only through the mask, dropped by the clear
    task t_irq;
        @(posedge core_clk);
        aux_ot_in <= 1'b1;
        wt(10);
        @(posedge core_clk);
        aux_ot_in <= 1'b0;
        wt(8);
        chk("irq masked", {7'h0, irq}, 8'h00);
        wr(8'h83, 8'h04);
        wt(2);
        chk("irq on", {7'h0, irq}, 8'h01);
        rdchk("mask", 8'h03, 8'h04);
        wr(8'h80, 8'h04);
        wt(2);
        chk("irq clr", {7'h0, irq}, 8'h00);
        rdchk("stat periph", 8'h00, 8'h01);
    endtask : t_irq

    // a mid-run reset drops every output and register at once
    task t_reset;
        wr(8'h82, 8'h03);
        wr(8'h83, 8'hff);
        wt(2);
        chk("rst pre", {xcvr_tx_en, 1'b0, irq, aux_supply_output, boost_on}, 8'hf7);
        @(posedge core_clk);
        rst <= 1'b1;
        #1;
        chk("rst outs", {xcvr_tx_en, 1'b0, irq, aux_supply_output, boost_on}, 8'h00);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wt(2);
        rdchk("rst ctrl", 8'h02, 8'h00);
        rdchk("rst mask", 8'h03, 8'h00);
    endtask : t_reset

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {xcvr_ot_in, boost_overtemp_flag_in, aux_ot_in, main_ot_in} = '0;
        {main_pw_in, main_pwm_mode, other_fs_req} = '0;
        mismatches = 0;
        checks_done = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        wt(2);
        rdchk("stat rst", 8'h00, 8'h00);
        t_aux();
        t_boost();
        t_xcvr();
        t_main();
        t_prewarn();
        t_other();
        t_irq();
        t_reset();
        results();
    end

    // a hang costs a mismatch rather than a stuck run
    initial begin
        #200us;
        mismatches++;
        results();
    end
endmodule : test_thermal_protection_supervisor
`default_nettype wire
